// file: hdl/atpwm_pkg.sv
/*
  Shared constants of the angle to PWM output stage: clock rate, carrier
  rate, duty band, angle and span encodings.
  Assumes a single 100 MHz clock and a full-turn angle word of 12 bits.
*/
package atpwm_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ       = 100_000_000;
  localparam int PWM_HZ       = 244;
  localparam int PERIOD_CYC   = CLK_HZ / PWM_HZ;
  localparam int MIN_DUTY_PCT = 10;
  localparam int MAX_DUTY_PCT = 90;
  localparam int PCT_FULL     = 100;

  // ****************************************************************
  // Widths and encodings
  // ****************************************************************
  localparam int CNT_W      = 19;
  localparam int ANGLE_W    = 12;
  localparam int SPAN_W     = 9;
  localparam int PROD_W     = 21;
  localparam int CODE_W     = 12;
  localparam int MUL_W      = 31;
  localparam logic [SPAN_W-1:0] SPAN_MIN_DEG   = 9'h007;
  localparam logic [SPAN_W-1:0] SPAN_MAX_DEG   = 9'h168;
  localparam logic [CODE_W-1:0] CODE_MAX       = 12'hfff;

endpackage

// file: hdl/atpwm_span_div.sv
/*
  Sequential restoring divider that scales the angle product by the span.
  Assumes a synchronised active-low reset and a start pulse only while idle.
*/
`timescale 1ns/10ps
module atpwm_span_div
  import atpwm_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rstn,
  input  wire logic              i_start,
  input  wire logic [PROD_W-1:0] i_dividend,
  input  wire logic [SPAN_W-1:0] i_divisor,
  output logic                   o_done,
  output logic [PROD_W-1:0]      o_quot
);

  // ****************************************************************
  // Divider state
  // ****************************************************************
  // One quotient bit a cycle; done long before the next period starts.
  logic [PROD_W-1:0] dvd_r;
  logic [SPAN_W-1:0] div_r;
  logic [SPAN_W:0]   rem_r;
  logic [4:0]        bits_r;
  logic              busy_r;
  logic [SPAN_W:0]   rem_sh;
  logic              fits;

  assign rem_sh = {rem_r[SPAN_W-1:0], dvd_r[PROD_W-1]};
  assign fits   = rem_sh >= {1'b0, div_r};

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      dvd_r  <= '0;
      div_r  <= '0;
      rem_r  <= '0;
      bits_r <= '0;
      busy_r <= 1'b0;
      o_done <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      if (i_start && !busy_r)
      begin
        dvd_r  <= i_dividend;
        div_r  <= i_divisor;
        rem_r  <= '0;
        bits_r <= 5'(PROD_W);
        busy_r <= 1'b1;
      end
      else if (busy_r)
      begin
        rem_r  <= fits ? rem_sh - {1'b0, div_r} : rem_sh;
        dvd_r  <= {dvd_r[PROD_W-2:0], fits};
        bits_r <= bits_r - 5'h01;
        if (bits_r == 5'h01)
        begin
          busy_r <= 1'b0;
          o_done <= 1'b1;
        end
      end
    end
  end

  assign o_quot = dvd_r;

endmodule

// file: hdl/atpwm_top.sv
/*
  Angle to PWM output stage: fixed-rate carrier whose high time follows
  the shaft angle across a configurable span, in either sense of rotation.
  Assumes angle, span and sense inputs synchronous to i_clk.
*/
`timescale 1ns/10ps
module atpwm_top
  import atpwm_pkg::*;
#(
  parameter int P_PERIOD_CYCLES = PERIOD_CYC
)
(
  input  wire logic               i_clk,
  input  wire logic               i_rstn,
  input  wire logic [ANGLE_W-1:0] i_angle,
  input  wire logic [SPAN_W-1:0]  i_span_deg,
  input  wire logic               i_counterclockwise_option,
  output logic                    o_pwm
);

  localparam logic [CNT_W-1:0] PERIOD_M1 = CNT_W'(P_PERIOD_CYCLES - 1);
  localparam logic [CNT_W-1:0] MIN_HIGH  =
    CNT_W'(P_PERIOD_CYCLES * MIN_DUTY_PCT / PCT_FULL);
  localparam logic [CNT_W-1:0] MAX_HIGH  =
    CNT_W'(P_PERIOD_CYCLES * MAX_DUTY_PCT / PCT_FULL);
  localparam logic [MUL_W-1:0] BAND_HIGH = MUL_W'(MAX_HIGH - MIN_HIGH);
  localparam logic [CNT_W:0]   PERIOD_W  = (CNT_W+1)'(P_PERIOD_CYCLES);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [CNT_W-1:0] calc_high(input logic [CODE_W-1:0] code);
    logic [MUL_W-1:0] prod;
    prod      = MUL_W'(code) * BAND_HIGH / MUL_W'(CODE_MAX);
    calc_high = MIN_HIGH + prod[CNT_W-1:0];
  endfunction

  function automatic logic [SPAN_W-1:0] clamp_span(input logic [SPAN_W-1:0] s);
    if (s < SPAN_MIN_DEG)
      clamp_span = SPAN_MIN_DEG;
    else if (s > SPAN_MAX_DEG)
      clamp_span = SPAN_MAX_DEG;
    else
      clamp_span = s;
  endfunction

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic [1:0] rst_sync_r;
  logic       rstn;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end

  assign rstn = rst_sync_r[1];

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!rstn);

  // ****************************************************************
  // Period counter
  // ****************************************************************
  logic [CNT_W-1:0] cnt_r;
  logic             wrap;

  assign wrap = cnt_r == PERIOD_M1;

  always_ff @(posedge i_clk or negedge rstn)
  begin
    if (!rstn)
      cnt_r <= '0;
    else
      cnt_r <= wrap ? '0 : cnt_r + 19'h00001;
  end

  chk_period_wrap_back: assert property (wrap |=> cnt_r == '0)
    else $error("Period counter did not wrap to zero.");

  // ****************************************************************
  // Angle scaling
  // ****************************************************************
  logic [SPAN_W-1:0] span_eff;
  logic [PROD_W-1:0] dividend;
  logic              div_done;
  logic [PROD_W-1:0] quot;
  logic [CODE_W-1:0] q_clamp;
  logic [CODE_W-1:0] code_nxt;
  logic              ccw_r;
  logic [PROD_W-1:0] dvd_samp_r;
  logic [SPAN_W-1:0] span_samp_r;

  assign span_eff = clamp_span(i_span_deg);
  assign dividend = PROD_W'(i_angle) * PROD_W'(SPAN_MAX_DEG);

  chk_span_band_legal: assert property (span_eff >= SPAN_MIN_DEG && span_eff <= SPAN_MAX_DEG)
    else $error("Effective span outside legal range.");

  atpwm_span_div u_div
  (
    .i_clk      (i_clk),
    .i_rstn     (rstn),
    .i_start    (wrap),
    .i_dividend (dividend),
    .i_divisor  (span_eff),
    .o_done     (div_done),
    .o_quot     (quot)
  );

  always_ff @(posedge i_clk or negedge rstn)
  begin
    if (!rstn)
      ccw_r <= 1'b0;
    else if (wrap)
      ccw_r <= i_counterclockwise_option;
  end

  always_ff @(posedge i_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dvd_samp_r  <= '0;
      span_samp_r <= SPAN_MIN_DEG;
    end
    else if (wrap)
    begin
      dvd_samp_r  <= dividend;
      span_samp_r <= span_eff;
    end
  end

  // Quotient saturates at 12-bit full scale.
  assign q_clamp  = (quot > PROD_W'(CODE_MAX)) ? CODE_MAX : quot[CODE_W-1:0];
  // Sense of rotation flips the code.
  assign code_nxt = ccw_r ? CODE_MAX - q_clamp : q_clamp;

  // Clockwise code follows the scaled angle.
  chk_cw_code_rise: assert property (div_done && !ccw_r |->
    22'(code_nxt) * 22'(span_samp_r) <= 22'(dvd_samp_r) &&
    (code_nxt == CODE_MAX ||
     22'(dvd_samp_r) < (22'(code_nxt) + 22'h000001) * 22'(span_samp_r)))
    else $error("Clockwise code does not follow angle.");
  // Counterclockwise code mirrors the scaled angle.
  chk_ccw_code_fall: assert property (div_done && ccw_r |->
    22'(CODE_MAX - code_nxt) * 22'(span_samp_r) <= 22'(dvd_samp_r) &&
    (code_nxt == '0 ||
     22'(dvd_samp_r) < (22'(CODE_MAX - code_nxt) + 22'h000001) * 22'(span_samp_r)))
    else $error("Counterclockwise code not mirrored.");

  // ****************************************************************
  // Pulse width
  // ****************************************************************
  // Holding a pending width costs one period of latency but keeps every
  // period whole when the angle moves.
  logic [CNT_W-1:0]  pend_high_r;
  logic [CODE_W-1:0] pend_code_r;
  logic [CNT_W-1:0]  high_r;

  // Width maps code onto the band.
  always_ff @(posedge i_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pend_high_r <= MIN_HIGH;
      pend_code_r <= '0;
    end
    else if (div_done)
    begin
      pend_high_r <= calc_high(code_nxt);
      pend_code_r <= code_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge rstn)
  begin
    if (!rstn)
      high_r <= MIN_HIGH;
    else if (wrap)
      high_r <= pend_high_r;
  end

  // Width changes only at period start.
  chk_width_load_edge: assert property ($changed(high_r) |-> cnt_r == '0)
    else $error("Pulse width changed mid-period.");
  // End codes give the band edges.
  chk_end_duty_map: assert property (wrap && pend_code_r == '0 |=> high_r == MIN_HIGH)
    else $error("Zero angle did not give minimum duty.");
  chk_full_duty_map: assert property (wrap && pend_code_r == CODE_MAX |=> high_r == MAX_HIGH)
    else $error("Full angle did not give maximum duty.");
  chk_width_in_band: assert property (high_r >= MIN_HIGH && high_r <= MAX_HIGH)
    else $error("Pulse width outside duty band.");

  // ****************************************************************
  // Output
  // ****************************************************************
  always_ff @(posedge i_clk or negedge rstn)
  begin
    if (!rstn)
      o_pwm <= 1'b0;
    else
      o_pwm <= cnt_r < high_r;
  end

  // ****************************************************************
  // Output checks
  // ****************************************************************
  logic           pwm_d_r;
  logic           seen_r;
  logic [CNT_W:0] since_rise_r;
  logic [CNT_W:0] high_len_r;
  logic           rise;
  logic           fall;

  assign rise = o_pwm && !pwm_d_r;
  assign fall = !o_pwm && pwm_d_r;

  always_ff @(posedge i_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pwm_d_r      <= 1'b0;
      seen_r       <= 1'b0;
      since_rise_r <= '0;
      high_len_r   <= '0;
    end
    else
    begin
      pwm_d_r      <= o_pwm;
      seen_r       <= seen_r | rise;
      since_rise_r <= rise ? 20'h00001 : since_rise_r + 20'h00001;
      high_len_r   <= o_pwm ? high_len_r + 20'h00001 : '0;
    end
  end

  // Rising edges exactly one period apart.
  chk_period_len_fixed: assert property (rise && seen_r |-> since_rise_r == PERIOD_W)
    else $error("Output period length changed.");
  // High pulse never shorter than minimum.
  chk_min_pulse_len: assert property (fall |-> high_len_r >= {1'b0, MIN_HIGH})
    else $error("High pulse shorter than minimum.");
  // High pulse never longer than maximum.
  chk_max_pulse_len: assert property (fall |-> high_len_r <= {1'b0, MAX_HIGH})
    else $error("High pulse longer than maximum.");

endmodule

// file: tb/angle_to_pwm_output_bench.sv
/*
  Self-checking bench of the angle to PWM stage with a capture model.
  Assumes a shortened period; inputs change once per period, each checked.
*/
`timescale 1ns/10ps
module angle_to_pwm_output_bench
  import atpwm_pkg::*;
;
  localparam int P = 1000;
  logic               i_clk  = 1'b0;
  logic               i_rstn = 1'b0;
  logic [ANGLE_W-1:0] angle  = '0;
  logic [SPAN_W-1:0]  span   = 9'h168;
  logic               counterclockwise_option    = 1'b0;
  logic               o_pwm;
  logic               hv;
  logic               pv;
  logic [31:0]        hc;
  logic [31:0]        pc;
  logic               prev_pwm = 1'b0;
  int                 n_errors = 0;
  int                 n_tests  = 0;
  int                 seed     = 32'h4c16536f;
  int                 e;
  int                 exp_q[$];
  logic [11:0] ta[12] = '{12'h000, 12'hfff, 12'h000, 12'hfff, 12'h800, 12'h800,
                          12'h04f, 12'h04f, 12'h3e8, 12'h000, 12'hfff, 12'h001};
  logic [8:0]  ts[12] = '{9'h168, 9'h168, 9'h168, 9'h168, 9'h168, 9'h168,
                          9'h007, 9'h006, 9'h190, 9'h000, 9'h0b4, 9'h168};
  logic        tc[12] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1,
                          1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};

  initial forever #5 i_clk = ~i_clk;

  atpwm_top #(.P_PERIOD_CYCLES(P)) dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_angle(angle),
    .i_span_deg(span), .i_counterclockwise_option(counterclockwise_option), .o_pwm(o_pwm));
  atpwm_capture_model cap_u (.i_clk(i_clk), .i_pwm(o_pwm), .o_high_vld(hv),
    .o_high_cyc(hc), .o_per_vld(pv), .o_per_cyc(pc));

  // ****************************************************************
  // Expectations and checks
  // ****************************************************************
  function automatic int exp_h(int a, int s, bit c);
    int sp;
    int code;
    int lo;
    sp   = (s < int'(SPAN_MIN_DEG)) ? int'(SPAN_MIN_DEG) : s;
    sp   = (sp > int'(SPAN_MAX_DEG)) ? int'(SPAN_MAX_DEG) : sp;
    code = a * 360 / sp;
    code = (code > int'(CODE_MAX)) ? int'(CODE_MAX) : code;
    code = c ? int'(CODE_MAX) - code : code;
    lo   = P * MIN_DUTY_PCT / PCT_FULL;
    return lo + code * (P * MAX_DUTY_PCT / PCT_FULL - lo) / int'(CODE_MAX);
  endfunction

  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic cmp_high(input logic [31:0] got, input logic [31:0] want);
    n_tests++;
    if (got !== want)
    begin
      n_errors++;
      $display("[ERR] %0t high time got %h want %h", $time, got, want);
    end
  endtask

  task automatic cmp_per(input logic [31:0] got, input logic [31:0] want);
    n_tests++;
    if (got !== want)
    begin
      n_errors++;
      $display("[ERR] %0t period got %h want %h", $time, got, want);
    end
  endtask

  // Periods before the first driven values carry don't-care notes of -1.
  always @(negedge i_clk)
  begin
    if (hv === 1'b1 && exp_q.size() == 0)
    begin
      n_errors++;
      $display("[ERR] %0t unexpected pulse got %h want %h", $time, hc, 0);
    end
    if (hv === 1'b1 && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      if (e >= 0)
        cmp_high(hc, e[31:0]);
    end
    if (pv === 1'b1)
      cmp_per(pc, P);
  end

  // ****************************************************************
  // Stimulus
  // ****************************************************************
  task automatic wait_rise();
    int k;
    for (k = 0; k < 3 * P; k++)
    begin
      @(negedge i_clk);
      if (o_pwm === 1'b1 && prev_pwm === 1'b0)
      begin
        prev_pwm = 1'b1;
        return;
      end
      prev_pwm = o_pwm;
    end
    n_errors++;
    $display("[ERR] %0t no rising edge got %h want %h", $time, o_pwm, 1'b1);
    wrap_up();
  endtask

  // Values set after a rise show in the period two rises later.
  task automatic step(input logic [11:0] a, input logic [8:0] s, input logic c);
    wait_rise();
    angle = a;
    span  = s;
    counterclockwise_option   = c;
    exp_q.push_back(exp_h(a, s, c));
  endtask

  initial
  begin
    repeat (3) @(negedge i_clk);
    i_rstn = 1'b1;
    exp_q.push_back(-1);
    exp_q.push_back(-1);
    for (int i = 0; i < 12; i++)
      step(ta[i], ts[i], tc[i]);
    // random angles, spans and senses every period
    for (int i = 0; i < 20; i++)
      step(12'($random(seed)), 9'($random(seed)), 1'($random(seed)));
    repeat (3) wait_rise();
    if (exp_q.size() != 0)
    begin
      n_errors++;
      $display("[ERR] %0t pending got %h want %h", $time, exp_q.size(), 0);
    end
    wrap_up();
  end
endmodule

// file: tb/atpwm_capture_model.sv
/*
  Capture model of the far side: measures high time and period of the PWM.
  Assumes it shares the rising-edge clock of the pulse source.
*/
`timescale 1ns/10ps
module atpwm_capture_model
(
  input  wire logic   i_clk,
  input  wire logic   i_pwm,
  output logic        o_high_vld,
  output logic [31:0] o_high_cyc,
  output logic        o_per_vld,
  output logic [31:0] o_per_cyc
);
  logic        prev_r = 1'b0;
  logic        seen_r = 1'b0;
  logic [31:0] hi_r   = '0;
  logic [31:0] per_r  = '0;

  // The first rise has no earlier rise, so no period is reported for it.
  always @(posedge i_clk)
  begin
    o_high_vld <= 1'b0;
    o_per_vld  <= 1'b0;
    prev_r     <= i_pwm;
    per_r      <= per_r + 1;
    if (i_pwm)
      hi_r <= hi_r + 1;
    if (prev_r && !i_pwm)
    begin
      o_high_vld <= 1'b1;
      o_high_cyc <= hi_r;
      hi_r       <= '0;
    end
    if (i_pwm && !prev_r)
    begin
      per_r  <= 1;
      seen_r <= 1'b1;
      o_per_vld <= seen_r;
      o_per_cyc <= per_r;
    end
  end
endmodule
